// ===== hdl/tpsc_pkg.sv
// Constants and types for the tare and peak store control block
// What this block does
// - Tare capture starts only on rising edge
// - Captured tare held while powered
// - Reject tare when input exceeds overflow limit
// - Tare-valid output and indicator while valid
// - Store input selects gross or net signal
// - Current mode run follows selected input
// - Hold freezes stored value on output
// - Peak mode records minimum, maximum or span
// - Envelope moves peak linearly toward current
// - Unconnected control inputs read as low
// - Tare with store, or min/max without tare
// - Factory defaults after reset
// - Peak to current mode clears peak store
// - Net gain one-hot: 1, 2, 5, 10
// - Retained tare restored after power returns
package tpsc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] TPSC_OFS_CTRL = 12'h000;
  localparam logic [11:0] TPSC_OFS_STAT = 12'h004;
  localparam logic [11:0] TPSC_OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0] TPSC_OFS_IRQ_MASK = 12'h00C;
  localparam logic [11:0] TPSC_OFS_TARE = 12'h010;
  localparam logic [11:0] TPSC_OFS_STORE = 12'h014;
  localparam logic [11:0] TPSC_OFS_NET = 12'h018;
  localparam logic [11:0] TPSC_OFS_OVF = 12'h01C;
  localparam logic [11:0] TPSC_OFS_RATE = 12'h020;
  localparam logic [11:0] TPSC_OFS_NVM = 12'h024;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int TPSC_CTRL_RETAIN = 0;
  localparam int TPSC_CTRL_TFILT = 1;
  localparam int TPSC_CTRL_SFILT = 2;
  localparam int TPSC_CTRL_ENV = 3;
  localparam int TPSC_CTRL_SRC_NET = 4;
  localparam int TPSC_CTRL_MINMAX = 5;
  localparam int TPSC_CTRL_PKSEL = 6;
  localparam int TPSC_CTRL_GAIN = 8;
  localparam logic [11:0] TPSC_CTRL_RST = 12'h142;
  localparam logic [11:0] TPSC_CTRL_WMASK = 12'hFFF;

  // ****************************************
  // Peak kinds and gain codes
  // ****************************************
  localparam logic [1:0] TPSC_PK_MIN = 2'h0;
  localparam logic [1:0] TPSC_PK_MAX = 2'h1;
  localparam logic [1:0] TPSC_PK_P2P = 2'h2;
  localparam logic [3:0] TPSC_G1 = 4'h1;
  localparam logic [3:0] TPSC_G2 = 4'h2;
  localparam logic [3:0] TPSC_G5 = 4'h4;
  localparam logic [3:0] TPSC_G10 = 4'h8;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [15:0] TPSC_OVF_RST = 16'h6B33;
  localparam logic [15:0] TPSC_RATE_RST = 16'h0000;
  localparam int TPSC_DEB_CYC = 4;
  localparam int TPSC_IRQ_TARE_OK = 0;
  localparam int TPSC_IRQ_TARE_REJ = 1;
  localparam int TPSC_IRQ_W = 2;

endpackage

// ===== hdl/tpsc_sync.sv
// Three-stage synchroniser with agreement debounce
`timescale 1ns/1ps
module tpsc_sync
  import tpsc_pkg::*;
#(
  parameter int DEB = TPSC_DEB_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pin and clean level
  input wire logic i_pin,
  output logic o_level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic [7:0] cnt_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level accepted after stable agreement
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
      o_level <= 1'b0;
    end else if ((s2_q != s3_q) || (s3_q == o_level)) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == 8'(DEB - 1)) begin
      o_level <= s3_q;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

endmodule

// ===== hdl/tpsc_gain.sv
// Net signal gain stage with one-hot select
`timescale 1ns/1ps
module tpsc_gain
  import tpsc_pkg::*;
#(
  parameter int W = 16
) (
  // Data
  input wire logic signed [W-1:0] i_x,
  input wire logic [3:0] i_sel,
  output logic signed [W-1:0] o_y
);

  localparam logic signed [W+3:0] HI = (W+4)'((1 <<< (W-1)) - 1);
  localparam logic signed [W+3:0] LO = (W+4)'(-(1 <<< (W-1)));

  logic signed [W+3:0] p;

  always_comb begin
    p = (W+4)'(i_x);
    case (i_sel)
      TPSC_G2: p = (W+4)'(i_x) <<< 1;
      TPSC_G5: p = ((W+4)'(i_x) <<< 2) + (W+4)'(i_x);
      TPSC_G10: p = ((W+4)'(i_x) <<< 3) + ((W+4)'(i_x) <<< 1);
      default: p = (W+4)'(i_x);
    endcase
    if (p > HI) begin
      o_y = HI[W-1:0];
    end else if (p < LO) begin
      o_y = LO[W-1:0];
    end else begin
      o_y = p[W-1:0];
    end
  end

endmodule

// ===== hdl/tpsc_top.sv
// Tare and peak store control with APB registers
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module tpsc_top
  import tpsc_pkg::*;
#(
  parameter int W = 16,
  parameter int DEB = TPSC_DEB_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Control pins
  input wire logic i_tare_pin,
  input wire logic i_run_pin,
  input wire logic i_peak_pin,
  // Gross sample from amplifier
  input wire logic signed [W-1:0] i_gross,
  input wire logic i_sample_vld,
  // Nonvolatile tare copy
  input wire logic signed [W-1:0] i_nvm_tare,
  input wire logic i_nvm_valid,
  output logic o_nvm_we,
  output logic signed [W-1:0] o_nvm_data,
  // Outputs
  output logic o_tare_valid,
  output logic o_led,
  output logic signed [W-1:0] o_store,
  output logic signed [W-1:0] o_tare_out,
  output logic o_irq
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [11:0] ctrl_q;
  logic [15:0] ovf_q;
  logic [15:0] rate_q;
  logic [TPSC_IRQ_W-1:0] ist_q;
  logic [TPSC_IRQ_W-1:0] imask_q;
  logic [TPSC_IRQ_W-1:0] ev;
  logic signed [W-1:0] tare_q;
  logic tvalid_q;
  logic restored_q;
  logic tare_lv;
  logic tare_lv_q;
  logic tare_pend_q;
  logic tare_go;
  logic run_lv;
  logic hold_lv;
  logic peak_lv;
  logic peak_lv_q;
  logic signed [W-1:0] net;
  logic signed [W-1:0] net_g;
  logic signed [W-1:0] src;
  logic signed [W-1:0] mn_q;
  logic signed [W-1:0] mx_q;
  logic signed [W-1:0] cur_q;
  logic pk_init_q;
  logic [15:0] dcnt_q;
  logic dstep;
  logic [W-1:0] absg;
  logic over;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] rdata;

  // ****************************************
  // Control input conditioning
  // ****************************************
  // Open inputs read low via sync reset value
  tpsc_sync #(.DEB(DEB)) u_sync_tare (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_tare_pin),
    .o_level(tare_lv)
  );
  tpsc_sync #(.DEB(DEB)) u_sync_run (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_run_pin),
    .o_level(hold_lv)
  );
  // Open run pin reads low and selects run
  assign run_lv = !hold_lv;
  tpsc_sync #(.DEB(DEB)) u_sync_peak (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_peak_pin),
    .o_level(peak_lv)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tare_lv_q <= 1'b0;
      peak_lv_q <= 1'b0;
    end else begin
      tare_lv_q <= tare_lv;
      peak_lv_q <= peak_lv;
    end
  end

  // ****************************************
  // Tare capture
  // ****************************************
  assign absg = i_gross[W-1] ? W'(-i_gross) : W'(i_gross);
  assign over = ({{(16){1'b0}}, absg} > {{(W){1'b0}}, ovf_q});

  // Edge waits for the next valid sample
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tare_pend_q <= 1'b0;
    end else if (tare_lv && !tare_lv_q && !ctrl_q[TPSC_CTRL_MINMAX]) begin
      tare_pend_q <= 1'b1;
    end else if (tare_go) begin
      tare_pend_q <= 1'b0;
    end
  end
  assign tare_go = tare_pend_q && i_sample_vld && restored_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tare_q <= '0;
      tvalid_q <= 1'b0;
      restored_q <= 1'b0;
      o_nvm_we <= 1'b0;
      o_nvm_data <= '0;
    end else begin
      o_nvm_we <= 1'b0;
      if (!restored_q) begin
        restored_q <= 1'b1;
        if (i_nvm_valid) begin
          tare_q <= i_nvm_tare;
          tvalid_q <= 1'b1;
        end
      end else if (tare_go) begin
        if (over) begin
          tvalid_q <= 1'b0;
        end else begin
          tare_q <= i_gross;
          tvalid_q <= 1'b1;
          if (ctrl_q[TPSC_CTRL_RETAIN]) begin
            o_nvm_we <= 1'b1;
            o_nvm_data <= i_gross;
          end
        end
      end
    end
  end

  always_comb begin
    net = W'(i_gross - tare_q);
    if (!tvalid_q) begin
      net = i_gross;
    end
  end

  tpsc_gain #(.W(W)) u_gain (
    .i_x(net),
    .i_sel(ctrl_q[TPSC_CTRL_GAIN +: 4]),
    .o_y(net_g)
  );

  // Net is unamplified when feeding the store
  assign src = ctrl_q[TPSC_CTRL_SRC_NET] ? net : i_gross;

  // ****************************************
  // Envelope step divider
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dcnt_q <= 16'h0000;
    end else if (dstep) begin
      dcnt_q <= 16'h0000;
    end else begin
      dcnt_q <= dcnt_q + 16'h0001;
    end
  end
  assign dstep = (rate_q != 16'h0000) && (dcnt_q >= rate_q);

  // ****************************************
  // Store unit
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mn_q <= '0;
      mx_q <= '0;
      cur_q <= '0;
      pk_init_q <= 1'b0;
    end else if (peak_lv && !peak_lv_q) begin
      mn_q <= '0;
      mx_q <= '0;
      pk_init_q <= 1'b0;
    end else if (run_lv && i_sample_vld) begin
      if (peak_lv) begin
        cur_q <= src;
      end else if (!pk_init_q) begin
        mn_q <= src;
        mx_q <= src;
        pk_init_q <= 1'b1;
      end else begin
        if (src < mn_q) begin
          mn_q <= src;
        end else if (ctrl_q[TPSC_CTRL_ENV] && dstep) begin
          mn_q <= W'(mn_q + 1);
        end
        if (src > mx_q) begin
          mx_q <= src;
        end else if (ctrl_q[TPSC_CTRL_ENV] && dstep) begin
          mx_q <= W'(mx_q - 1);
        end
      end
    end
  end

  // Peak pin low selects peak mode, high current
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_store <= '0;
      o_tare_out <= '0;
      o_tare_valid <= 1'b0;
      o_led <= 1'b0;
    end else begin
      o_tare_valid <= tvalid_q;
      o_led <= tvalid_q;
      if (ctrl_q[TPSC_CTRL_MINMAX]) begin
        o_store <= mn_q;
        o_tare_out <= mx_q;
      end else begin
        if (i_sample_vld) begin
          o_tare_out <= net_g;
        end
        if (peak_lv && !peak_lv_q) begin
          o_store <= '0;
        end else if (run_lv || !peak_lv) begin
          if (!peak_lv) begin
            case (ctrl_q[TPSC_CTRL_PKSEL +: 2])
              TPSC_PK_MIN: o_store <= mn_q;
              TPSC_PK_P2P: o_store <= W'(mx_q - mn_q);
              default: o_store <= mx_q;
            endcase
          end else begin
            o_store <= cur_q;
          end
        end
      end
      // Hold keeps last presented value
      if (!run_lv && peak_lv && peak_lv_q && !ctrl_q[TPSC_CTRL_MINMAX]) begin
        o_store <= o_store;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign ev[TPSC_IRQ_TARE_OK] = tare_go && !over;
  assign ev[TPSC_IRQ_TARE_REJ] = tare_go && over;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ist_q <= '0;
    end else if (wr && (i_paddr == TPSC_OFS_IRQ_STAT)) begin
      ist_q <= (ist_q & ~i_pwdata[TPSC_IRQ_W-1:0]) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(ist_q & imask_q);
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign wr = i_psel && i_penable && i_pwrite && o_pready;
  assign rd = i_psel && !i_penable && !i_pwrite;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= TPSC_CTRL_RST;
      ovf_q <= TPSC_OVF_RST;
      rate_q <= TPSC_RATE_RST;
      imask_q <= '0;
    end else if (wr) begin
      if (i_paddr == TPSC_OFS_CTRL) begin
        ctrl_q <= i_pwdata[11:0] & TPSC_CTRL_WMASK;
      end else if (i_paddr == TPSC_OFS_OVF) begin
        ovf_q <= i_pwdata[15:0];
      end else if (i_paddr == TPSC_OFS_RATE) begin
        rate_q <= i_pwdata[15:0];
      end else if (i_paddr == TPSC_OFS_IRQ_MASK) begin
        imask_q <= i_pwdata[TPSC_IRQ_W-1:0];
      end
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    if (i_paddr == TPSC_OFS_CTRL) begin
      rdata = {20'h0_0000, ctrl_q};
    end else if (i_paddr == TPSC_OFS_STAT) begin
      rdata = {27'h000_0000, pk_init_q, peak_lv, run_lv, tare_lv, tvalid_q};
    end else if (i_paddr == TPSC_OFS_IRQ_STAT) begin
      rdata = 32'(ist_q);
    end else if (i_paddr == TPSC_OFS_IRQ_MASK) begin
      rdata = 32'(imask_q);
    end else if (i_paddr == TPSC_OFS_TARE) begin
      rdata = 32'(unsigned'(tare_q));
    end else if (i_paddr == TPSC_OFS_STORE) begin
      rdata = 32'(unsigned'(o_store));
    end else if (i_paddr == TPSC_OFS_NET) begin
      rdata = 32'(unsigned'(net_g));
    end else if (i_paddr == TPSC_OFS_OVF) begin
      rdata = {16'h0000, ovf_q};
    end else if (i_paddr == TPSC_OFS_RATE) begin
      rdata = {16'h0000, rate_q};
    end else if (i_paddr == TPSC_OFS_NVM) begin
      rdata = {31'h0000_0000, restored_q};
    end else begin
      hit = 1'b0;
    end
  end

  // No wait state: ready in first access cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable) begin
      o_pready <= 1'b1;
      o_pslverr <= !hit;
      o_prdata <= rd ? rdata : 32'h0000_0000;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

endmodule

// ===== verif/tpsc_top_assertions.sv
// Checker for the tare and peak store control block
`timescale 1ns/1ps
module tpsc_chk #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Pins and outputs
  input wire logic i_tare_pin,
  input wire logic i_run_pin,
  input wire logic i_peak_pin,
  input wire logic o_tare_valid,
  input wire logic o_led,
  input wire logic o_nvm_we,
  input wire logic signed [W-1:0] o_store
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_led_valid: assert property (o_led == o_tare_valid)
    else $error("led differs from tare valid");
  a_tare_edge: assert property (
    $rose(o_tare_valid) && $past(i_rst_n, 4)
    |-> $past(i_tare_pin, 2) && $past(i_tare_pin, 5))
    else $error("tare valid rose without tare edge");
  a_tare_keep: assert property (
    (!i_tare_pin)[*8] ##0 o_tare_valid |=> o_tare_valid)
    else $error("tare valid lost with pin low");
  a_hold_frozen: assert property (
    (i_run_pin && $stable(i_peak_pin))[*8] ##1
    (i_run_pin && $stable(i_peak_pin))[*4] |-> $stable(o_store))
    else $error("store moved during hold");
  a_nvm_pulse: assert property (o_nvm_we |=> !o_nvm_we)
    else $error("copy strobe longer than one cycle");
  a_ready_next: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready in first access cycle");
  a_ready_one: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
endmodule

bind tpsc_top tpsc_chk #(.W(W)) i_tpsc_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_tare_pin(i_tare_pin), .i_run_pin(i_run_pin),
  .i_peak_pin(i_peak_pin), .o_tare_valid(o_tare_valid),
  .o_led(o_led), .o_nvm_we(o_nvm_we), .o_store(o_store)
);

// ===== verif/tpsc_far.sv
// Upstream amplifier and nonvolatile tare copy
`timescale 1ns/1ps
module tpsc_far #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Wanted level and copy request
  input wire logic signed [W-1:0] i_level,
  input wire logic i_nvm_we,
  input wire logic signed [W-1:0] i_nvm_data,
  // Sample stream and stored copy
  output logic signed [W-1:0] o_gross,
  output logic o_vld,
  output logic signed [W-1:0] o_nvm_tare,
  output logic o_nvm_valid
);
  // Sample every second cycle, inverted in between
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vld <= 1'b0;
      o_gross <= '0;
    end else begin
      o_vld <= !o_vld;
      o_gross <= o_vld ? ~o_gross : i_level;
    end
  end
  // Copy survives reset
  initial begin
    o_nvm_tare = '0;
    o_nvm_valid = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_nvm_we) begin
      o_nvm_tare <= i_nvm_data;
      o_nvm_valid <= 1'b1;
    end
  end
endmodule

// ===== verif/tpsc_top_bench.sv
// Bench for the tare and peak store control block
`timescale 1ns/1ps
module tpsc_top_bench
  import tpsc_pkg::*;
;
  typedef struct packed {
    logic [11:0] c;
    logic r;
    logic p;
    logic [15:0] g;
    logic [15:0] e;
  } tpsc_row_s;
  localparam tpsc_row_s ROWS [17] = '{
    '{12'h142, 1'b1, 1'b1, 16'h0100, 16'h0100},
    '{12'h142, 1'b1, 1'b1, 16'h0200, 16'h0200},
    '{12'h142, 1'b0, 1'b1, 16'h0300, 16'h0200},
    '{12'h142, 1'b1, 1'b1, 16'h0050, 16'h0050},
    '{12'h142, 1'b1, 1'b0, 16'h0050, 16'h0050},
    '{12'h142, 1'b1, 1'b0, 16'h0020, 16'h0050},
    '{12'h142, 1'b1, 1'b0, 16'h0070, 16'h0070},
    '{12'h142, 1'b0, 1'b0, 16'h0010, 16'h0070},
    '{12'h142, 1'b0, 1'b1, 16'h0010, 16'h0000},
    '{12'h102, 1'b1, 1'b1, 16'h0040, 16'h0040},
    '{12'h102, 1'b1, 1'b0, 16'h0040, 16'h0040},
    '{12'h102, 1'b1, 1'b0, 16'h0030, 16'h0030},
    '{12'h102, 1'b1, 1'b0, 16'h0060, 16'h0030},
    '{12'h182, 1'b1, 1'b1, 16'h0040, 16'h0040},
    '{12'h182, 1'b1, 1'b0, 16'h0040, 16'h0000},
    '{12'h182, 1'b1, 1'b0, 16'h0060, 16'h0020},
    '{12'h182, 1'b1, 1'b0, 16'h0030, 16'h0030}
  };
  localparam logic [3:0] GS [4] = '{TPSC_G1, TPSC_G2, TPSC_G5, TPSC_G10};
  localparam logic [15:0] MS [4] = '{16'h0001, 16'h0002, 16'h0005, 16'h000A};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic tp = 1'b0;
  logic rp = 1'b0;
  logic pp = 1'b0;
  logic signed [15:0] lvl = 16'h0000;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, erv, vld, nvm_we, nvm_valid, tv, led, irq;
  logic signed [15:0] gross, nvm_data, nvm_tare, store, tout;
  logic [11:0] cur = 12'hFFF;
  int n_errors = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  tpsc_top i_tpsc_top (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_tare_pin(tp), .i_run_pin(rp), .i_peak_pin(pp),
    .i_gross(gross), .i_sample_vld(vld), .i_nvm_tare(nvm_tare),
    .i_nvm_valid(nvm_valid), .o_nvm_we(nvm_we), .o_nvm_data(nvm_data),
    .o_tare_valid(tv), .o_led(led), .o_store(store),
    .o_tare_out(tout), .o_irq(irq)
  );
  tpsc_far i_tpsc_far (
    .i_clk(clk), .i_rst_n(rst_n), .i_level(lvl), .i_nvm_we(nvm_we),
    .i_nvm_data(nvm_data), .o_gross(gross), .o_vld(vld),
    .o_nvm_tare(nvm_tare), .o_nvm_valid(nvm_valid)
  );
  // ****
  // Tasks
  // ****
  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wn(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      final_report();
    end
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  task automatic pulse;
    tp <= 1'b1;
    wn(16);
    tp <= 1'b0;
    wn(16);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    wn(2);
    rst_n <= 1'b1;
    wn(2);
    xfer(1'b0, TPSC_OFS_CTRL, 32'h0);
    chk({20'h0, rdv[11:0] & 12'hFEF}, {20'h0, TPSC_G1, TPSC_PK_MAX, 6'h02});
    rd(TPSC_OFS_OVF, {16'h0, TPSC_OVF_RST});
    rd(TPSC_OFS_RATE, 32'h0);
    rd(12'h0FC, 32'h0);
    chk({31'h0, erv}, 32'h1);
    chk({31'h0, tv}, 32'h0);
    for (int i = 0; i < 17; i++) begin
      if (ROWS[i].c !== cur) begin
        xfer(1'b1, TPSC_OFS_CTRL, {20'h0, ROWS[i].c});
      end
      cur = ROWS[i].c;
      rp <= !ROWS[i].r;
      pp <= ROWS[i].p;
      wn(10);
      lvl <= ROWS[i].g;
      wn(20);
      chk({16'h0, store}, {16'h0, ROWS[i].e});
    end
    pp <= 1'b1;
    lvl <= 16'h0100;
    xfer(1'b1, TPSC_OFS_CTRL, 32'h14A);
    xfer(1'b1, TPSC_OFS_RATE, 32'h4);
    wn(16);
    pp <= 1'b0;
    wn(16);
    lvl <= 16'h0000;
    wn(40);
    chk({31'h0, store < 16'h0100 && store > 16'h00EF}, 32'h1);
    pp <= 1'b1;
    xfer(1'b1, TPSC_OFS_CTRL, 32'h142);
    lvl <= 16'h0100;
    tp <= 1'b1;
    wn(2);
    tp <= 1'b0;
    wn(16);
    chk({31'h0, tv}, 32'h0);
    tp <= 1'b1;
    wn(16);
    chk({30'h0, tv, led}, 32'h3);
    rd(TPSC_OFS_TARE, 32'h0100);
    lvl <= 16'h0200;
    wn(16);
    rd(TPSC_OFS_TARE, 32'h0100);
    tp <= 1'b0;
    wn(16);
    chk({31'h0, tv}, 32'h1);
    for (int j = 0; j < 4; j++) begin
      xfer(1'b1, TPSC_OFS_CTRL, {20'h0, GS[j], 8'h42});
      wn(8);
      chk({16'h0, tout}, {16'h0, 16'h0100 * MS[j]});
    end
    xfer(1'b1, TPSC_OFS_CTRL, {20'h0, TPSC_G5, 8'h52});
    wn(16);
    chk({16'h0, store}, 32'h0100);
    rd(TPSC_OFS_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, TPSC_OFS_IRQ_MASK, 32'h3);
    wn(2);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, TPSC_OFS_IRQ_STAT, 32'h1);
    wn(2);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, TPSC_OFS_CTRL, 32'h142);
    lvl <= 16'h6B34;
    pulse();
    chk({30'h0, tv, led}, 32'h0);
    rd(TPSC_OFS_TARE, 32'h0100);
    chk({31'h0, irq}, 32'h1);
    lvl <= 16'h6B33;
    pulse();
    chk({31'h0, tv}, 32'h1);
    rd(TPSC_OFS_TARE, 32'h6B33);
    xfer(1'b1, TPSC_OFS_CTRL, 32'h162);
    lvl <= 16'h0011;
    pulse();
    rd(TPSC_OFS_TARE, 32'h6B33);
    xfer(1'b1, TPSC_OFS_CTRL, 32'h143);
    lvl <= 16'h0123;
    pulse();
    chk({16'h0, nvm_tare}, 32'h0123);
    rst_n <= 1'b0;
    wn(2);
    rst_n <= 1'b1;
    wn(4);
    rd(TPSC_OFS_TARE, 32'h0123);
    chk({31'h0, tv}, 32'h1);
    final_report();
  end
endmodule
